/* File: rtl/reference_trim_regs.svh */
`ifndef REFERENCE_TRIM_REGS_SVH
`define REFERENCE_TRIM_REGS_SVH

// register byte offsets, decoded on haddr[11:0]
`define CAL_RANGE_ADDR      12'h020
`define MARGIN_CTRL_ADDR    12'h030

// offset calibration range layout
`define CAL_SEL_MSB         2
`define CAL_SEL_LSB         0
`define CAL_SEL_WIDTH       3
`define CAL_RESET           3'h0

// reference margin control layout
`define MARGIN_EN_BIT       5
`define MARGIN_CODE_MSB     4
`define MARGIN_CODE_LSB     0
`define MARGIN_WIDTH        6
`define MARGIN_RESET        6'h00

// ahb-lite encodings
`define HTRANS_IDLE         2'h0
`define HRESP_OKAY          1'b0

`endif

/* File: rtl/reference_trim_pkg.sv */
`default_nettype none

package reference_trim_pkg;

   // calibration codes; the two top codes alias the 5.0 V setting
   typedef enum logic [2:0] {
      RANGE_5V0      = 3'h0,
      RANGE_4V5      = 3'h1,
      RANGE_4V096    = 3'h2,
      RANGE_3V3      = 3'h3,
      RANGE_3V0      = 3'h4,
      RANGE_2V5      = 3'h5,
      RANGE_5V0_ALT6 = 3'h6,
      RANGE_5V0_ALT7 = 3'h7
   } ref_range_t;

   // one bit per distinct reference voltage, bit 0 is 5.0 V
   typedef logic [5:0] range_onehot_t;

   // latched ahb address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic sel_cal;
      logic sel_margin;
      logic lane0;
   } ahb_req_t;

   typedef struct packed {
      logic       enable;
      logic [4:0] code;
   } margin_cfg_t;

endpackage : reference_trim_pkg

`default_nettype wire

/* File: rtl/trim_reg_cell.sv */
`timescale 1ns/1ps
`default_nettype none

module trim_reg_cell #(
   parameter int unsigned     W   = 8,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          we,
   input  wire logic [W-1:0]  wdata,
   output var  logic [W-1:0]  q
);

   logic [W-1:0] d;

   always_comb begin
      d = q;
      if (we) begin
         d = wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

endmodule : trim_reg_cell

`default_nettype wire

/* File: rtl/reference_trim_registers.sv */
`timescale 1ns/1ps
`default_nettype none

`include "reference_trim_regs.svh"

// Overview of operation
// - calibration register bits 7..3 always read back as zero
// - calibration bits 2..0 writable; codes 6 and 7 also select 5.0 V
// - margin register decoded at 030h, every bit zero after reset
// - margin register bits 7..6 always read back as zero
// - margin bit 5 is a writable enable, cleared by reset
// - margin bits 4..0 hold a writable code, cleared by reset
// - margin code is signed: zero none, 1..15 up, 16..31 down
module reference_trim_registers (
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output var  logic                          hreadyout,
   output var  logic [31:0]                   hrdata,
   output var  logic                          hresp,
   output var  reference_trim_pkg::ref_range_t   ref_range_select,
   output var  reference_trim_pkg::range_onehot_t ref_range_onehot,
   output var  logic                          margin_enable,
   output var  logic [4:0]                    margin_code,
   output var  logic signed [4:0]             margin_shift_code,
   output var  logic                          margin_shift_negative,
   output var  logic                          margin_shift_active
);
   import reference_trim_pkg::*;

   // ---------------- bus address phase ----------------
   ahb_req_t    req_d;
   ahb_req_t    req_q;
   logic        acc;
   logic        acc_read;
   logic        hit_cal;
   logic        hit_margin;

   assign acc        = hsel && hready && (htrans[1] == 1'b1);
   assign acc_read   = acc && !hwrite;
   assign hit_cal    = (haddr[11:0] == `CAL_RANGE_ADDR);
   assign hit_margin = (haddr[11:0] == `MARGIN_CTRL_ADDR);

   always_comb begin
      req_d            = '0;
      if (acc) begin
         req_d.valid      = 1'b1;
         req_d.write      = hwrite;
         req_d.sel_cal    = hit_cal;
         req_d.sel_margin = hit_margin;
         // narrow writes that miss byte lane 0 leave the fields alone
         req_d.lane0      = (haddr[1:0] == 2'h0);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // ---------------- register storage ----------------
   logic                       cal_we;
   logic                       margin_we;
   logic [`CAL_SEL_WIDTH-1:0]  cal_q;
   logic [`MARGIN_WIDTH-1:0]   margin_q;
   margin_cfg_t                mcfg;

   assign cal_we    = req_q.valid && req_q.write && req_q.sel_cal &&
                      req_q.lane0;
   assign margin_we = req_q.valid && req_q.write && req_q.sel_margin &&
                      req_q.lane0;

   trim_reg_cell #(
      .W   (`CAL_SEL_WIDTH),
      .RST (`CAL_RESET)
   ) u_cal (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (cal_we),
      .wdata   (hwdata[`CAL_SEL_MSB:`CAL_SEL_LSB]),
      .q       (cal_q)
   );

   // enable and code, both reset to zero
   trim_reg_cell #(
      .W   (`MARGIN_WIDTH),
      .RST (`MARGIN_RESET)
   ) u_margin (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (margin_we),
      .wdata   (hwdata[`MARGIN_EN_BIT:`MARGIN_CODE_LSB]),
      .q       (margin_q)
   );

   assign mcfg = margin_cfg_t'(margin_q);

   // ---------------- read data ----------------
   // a read whose address phase overlaps a pending write data phase to
   // the same register sees the new value, not the stale one
   logic [`CAL_SEL_WIDTH-1:0]  cal_fwd;
   logic [`MARGIN_WIDTH-1:0]   margin_fwd;
   logic [31:0]                hrdata_d;
   logic                       hreadyout_d;
   logic                       hresp_d;

   always_comb begin
      cal_fwd    = cal_q;
      margin_fwd = margin_q;
      if (cal_we) begin
         cal_fwd = hwdata[`CAL_SEL_MSB:`CAL_SEL_LSB];
      end
      if (margin_we) begin
         margin_fwd = hwdata[`MARGIN_EN_BIT:`MARGIN_CODE_LSB];
      end
   end

   always_comb begin
      hrdata_d    = 32'h0000_0000;
      // zero wait states, so the slave is never busy
      hreadyout_d = 1'b1;
      hresp_d     = `HRESP_OKAY;
      if (acc_read) begin
         if (hit_cal) begin
            hrdata_d[`CAL_SEL_MSB:`CAL_SEL_LSB] = cal_fwd;
         end else if (hit_margin) begin
            hrdata_d[`MARGIN_EN_BIT:`MARGIN_CODE_LSB] = margin_fwd;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= `HRESP_OKAY;
      end else begin
         hrdata    <= hrdata_d;
         hreadyout <= hreadyout_d;
         hresp     <= hresp_d;
      end
   end

   // ---------------- analogue control outputs ----------------
   // registered once more so every output comes from a flop; they lag
   // the stored fields by one cycle
   ref_range_t            range_d;
   range_onehot_t         onehot_d;
   logic                  men_d;
   logic [4:0]            mcode_d;
   logic signed [4:0]     shift_d;
   logic                  neg_d;
   logic                  active_d;

   always_comb begin
      range_d  = ref_range_t'(cal_q);
      onehot_d = 6'h01;
      // code decode with 5.0 V aliases
      unique case (ref_range_t'(cal_q))
         RANGE_5V0:      onehot_d = 6'h01;
         RANGE_4V5:      onehot_d = 6'h02;
         RANGE_4V096:    onehot_d = 6'h04;
         RANGE_3V3:      onehot_d = 6'h08;
         RANGE_3V0:      onehot_d = 6'h10;
         RANGE_2V5:      onehot_d = 6'h20;
         RANGE_5V0_ALT6: onehot_d = 6'h01;
         RANGE_5V0_ALT7: onehot_d = 6'h01;
      endcase
   end

   always_comb begin
      men_d    = mcfg.enable;
      mcode_d  = mcfg.code;
      shift_d  = 5'sh00;
      neg_d    = 1'b0;
      active_d = 1'b0;
      if (mcfg.enable) begin
         // two's complement, 10000b is the deepest step down
         shift_d  = $signed(mcfg.code);
         neg_d    = mcfg.code[4];
         active_d = (mcfg.code != 5'h00);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_range_select      <= RANGE_5V0;
         ref_range_onehot      <= 6'h01;
         margin_enable         <= 1'b0;
         margin_code           <= 5'h00;
         margin_shift_code     <= 5'sh00;
         margin_shift_negative <= 1'b0;
         margin_shift_active   <= 1'b0;
      end else begin
         ref_range_select      <= range_d;
         ref_range_onehot      <= onehot_d;
         margin_enable         <= men_d;
         margin_code           <= mcode_d;
         margin_shift_code     <= shift_d;
         margin_shift_negative <= neg_d;
         margin_shift_active   <= active_d;
      end
   end

   // ---------------- assertions ----------------
   AST_CAL_RESERVED_ZERO: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc_read && hit_cal) |=> (hrdata[31:3] == 29'h0000_0000))
      else $error("calibration reserved bits read nonzero");

   AST_CAL_WRITE_TAKES: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc && hwrite && hit_cal && (haddr[1:0] == 2'h0)) ##1 1'b1
      |=> (cal_q == $past(hwdata[2:0])) ##1
          (ref_range_select == ref_range_t'($past(hwdata[2:0], 2))))
      else $error("calibration write not stored or not driven out");

   AST_RANGE_ALIAS_5V0: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cal_q[2:1] == 2'h3) |=> (ref_range_onehot == 6'h01))
      else $error("top calibration codes do not select 5.0 V");

   AST_MARGIN_DECODE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc && hwrite && hit_margin && (haddr[1:0] == 2'h0)) ##1 1'b1
      |=> (margin_q == $past(hwdata[5:0])))
      else $error("write at margin offset not stored");

   AST_MARGIN_RESERVED_ZERO: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc_read && hit_margin) |=> (hrdata[31:6] == 26'h000_0000))
      else $error("margin reserved bits read nonzero");

   AST_MARGIN_OFF_NO_SHIFT: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !margin_enable |-> ((margin_shift_code == 5'sh00) &&
                          !margin_shift_active && !margin_shift_negative))
      else $error("shift applied while margining disabled");

   AST_MARGIN_CODE_READBACK: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc_read && hit_margin && !margin_we)
      |=> (hrdata[5:0] == $past(margin_q)))
      else $error("margin readback differs from stored value");

   AST_MARGIN_SIGNED: assert property (
      @(posedge hclk) disable iff (!hresetn)
      margin_enable |-> ((margin_shift_negative == margin_code[4]) &&
                         (margin_shift_code == $signed(margin_code)) &&
                         (margin_shift_active == (margin_code != 5'h00))))
      else $error("margin code sign handling wrong");

   AST_CAL_RESET_ZERO: assert property (
      @(posedge hclk)
      !hresetn |-> ((cal_q == 3'h0) && (ref_range_select == RANGE_5V0)))
      else $error("calibration select not cleared by reset");

   AST_MARGIN_RESET_ZERO: assert property (
      @(posedge hclk)
      !hresetn |-> ((margin_q == 6'h00) && !margin_enable &&
                    (margin_code == 5'h00)))
      else $error("margin register not cleared by reset");

   AST_CAL_HOLDS: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !cal_we |=> $stable(cal_q))
      else $error("calibration select changed without a write");

   AST_MARGIN_HOLDS: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !margin_we |=> $stable(margin_q))
      else $error("margin register changed without a write");

   AST_MARGIN_ENABLE_OUT: assert property (
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (margin_enable == $past(margin_q[`MARGIN_EN_BIT])))
      else $error("margin enable output does not follow the register");

   AST_MARGIN_CODE_OUT: assert property (
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (margin_code == $past(margin_q[4:0])))
      else $error("margin code output does not follow the register");

   AST_RANGE_ONEHOT_DECODE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cal_q <= 3'h5) |=> (ref_range_onehot == (6'h01 << $past(cal_q))))
      else $error("calibration code decodes to the wrong range");

   AST_UNMAPPED_READ_ZERO: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc_read && !hit_cal && !hit_margin) |=> (hrdata == 32'h0000_0000))
      else $error("read outside the two registers returned data");

endmodule : reference_trim_registers

`default_nettype wire

/* File: bench/reference_trim_registers_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module reference_trim_registers_tb;
   import reference_trim_pkg::*;

   logic          hclk;
   logic          hresetn;
   logic          hsel;
   logic [31:0]   haddr;
   logic [1:0]    htrans;
   logic          hwrite;
   logic [2:0]    hsize;
   logic [31:0]   hwdata;
   logic          hreadyout;
   logic [31:0]   hrdata;
   logic          hresp;
   ref_range_t    rsel;
   range_onehot_t onehot;
   logic          men;
   logic [4:0]    mcode;
   logic [4:0]    mshift;
   logic          mneg;
   logic          mact;
   int            mismatches;
   int            checks_done;
   logic [31:0]   rd;
   logic [31:0]   rnd;
   logic [5:0]    v;
   logic [5:0]    corner [9] = '{6'h00, 6'h0f, 6'h10, 6'h1f, 6'h20,
                                 6'h2f, 6'h30, 6'h3f, 6'h21};

   reference_trim_registers dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .ref_range_select(rsel), .ref_range_onehot(onehot),
      .margin_enable(men), .margin_code(mcode),
      .margin_shift_code(mshift), .margin_shift_negative(mneg),
      .margin_shift_active(mact)
   );

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // one single transfer; hready and read data taken at rising edges
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] w, output logic [31:0] r);
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer

   function automatic logic [5:0] exp_onehot(input logic [2:0] c);
      return (c > 3'h5) ? 6'h01 : 6'h01 << c;
   endfunction : exp_onehot

   // enable, code, shift, negative, active
   function automatic logic [12:0] exp_margin(input logic [5:0] x);
      logic [4:0] s;
      s = x[5] ? x[4:0] : 5'h00;
      return {x[5], x[4:0], s, s[4], s != 5'h00};
   endfunction : exp_margin

   // outputs follow the register one edge after it stores
   task automatic chk_outs(input logic [2:0] c, input logic [5:0] m);
      repeat (2) @(negedge hclk);
      chk({29'h0, rsel}, {29'h0, c}, "range select");
      chk({26'h0, onehot}, {26'h0, exp_onehot(c)}, "range onehot");
      chk({19'h0, men, mcode, mshift, mneg, mact},
          {19'h0, exp_margin(m)}, "margin outputs");
      chk({31'h0, hresp}, 32'h0, "hresp");
      chk({31'h0, hreadyout}, 32'h1, "hreadyout");
      chk(hrdata, 32'h0, "hrdata idle");
      @(posedge hclk);
   endtask : chk_outs

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      summarize();
   end

   initial begin
      hresetn = 1'b0;
      hsel    = 1'b1;
      haddr   = 32'h0;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      void'($urandom(163));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, 32'h20, 32'h0, rd);
      chk(rd, 32'h0, "cal reset");
      xfer(1'b0, 32'h30, 32'h0, rd);
      chk(rd, 32'h0, "margin reset");
      chk_outs(3'h0, 6'h00);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         rnd = $urandom;
         xfer(1'b1, 32'h20, {rnd[31:3], 3'(c)}, rd);
         xfer(1'b0, 32'h20, 32'h0, rd);
         chk(rd, {29'h0, 3'(c)}, "cal readback");
         chk_outs(3'(c), 6'h00);
      end
      $display("test calibration done");
      for (int i = 0; i < 21; i++) begin
         v = (i < 9) ? corner[i] : 6'($urandom);
         rnd = $urandom;
         xfer(1'b1, 32'h30, {rnd[31:6], v}, rd);
         xfer(1'b0, 32'h30, 32'h0, rd);
         chk(rd, {26'h0, v}, "margin readback");
         chk_outs(3'h7, v);
      end
      $display("test margin done");
      xfer(1'b1, 32'h34, 32'hffffffff, rd);
      xfer(1'b1, 32'h31, 32'hffffffff, rd);
      xfer(1'b0, 32'h34, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      xfer(1'b0, 32'h30, 32'h0, rd);
      chk(rd, {26'h0, v}, "margin kept");
      $display("test unmapped done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, 32'h30, 32'h0, rd);
      chk(rd, 32'h0, "margin after reset");
      chk_outs(3'h0, 6'h00);
      $display("test mid reset done");
      summarize();
   end

endmodule : reference_trim_registers_tb

`default_nettype wire
